// File: src/ppc_power_attach.sv
`timescale 1ns/1ps
// Functional notes
// RULE1: Two bidirectional high-voltage paths, each configurable as sink or source.
// RULE2: Firmware should make the first path sink, the second path source.
// RULE3: Overcurrent clamp active only on a sourcing path, at firmware-chosen limit.
// RULE4: Clamped overcurrent lasting past the deglitch time latches the switch off.
// RULE5: Forward drop at trip current level latches the switch off.
// RULE6: VBUS above overvoltage or below undervoltage threshold disables the paths.
// RULE7: Comparator reverse mode as source, ideal-diode as sink; both disable switch.
// RULE8: Comparator mode blocks VBUS-to-internal-node current past the reverse trip.
// RULE9: Ideal-diode mode blocks current from internal node out to VBUS.
// RULE10: External path enables active high, dropped on overvoltage or undervoltage.
// RULE11: External paths get no overcurrent or thermal shutdown, only voltage limits.
// RULE12: Board pulls each used external enable low with a resistor.
// RULE13: Cable supply switch feeds VCONN to exactly one selected CC pin.
// RULE14: Enabled cable supply switch limits current as a constant current source.
// RULE15: No reverse blocking on the cable supply switch while it conducts.
// RULE16: Cable supply switch closes only if its input is above input-good.
// RULE17: Later input-good loss does not by itself open the closed switch.
// RULE18: Switch off and VBUS above safe five volts turns on the pull-down.
// RULE19: Pull-down held until safe zero level, within the discharge time; code holds it only with zero_tgt set, else releases at safe five.
// RULE20: Both CC open: monitor both, apply neither VBUS nor VCONN.
// RULE21: Rd and open: apply VBUS, no VCONN, watch the Rd pin.
// RULE22: Ra and open: watch both pins, apply neither VBUS nor VCONN.
// RULE23: Ra and Rd: VBUS on, VCONN on Ra pin, watch only Rd pin.
// RULE24: Rd on both: debug accessory, either pin senses detach.
// RULE25: Overcurrent latch holds switch off until firmware clears it; flag readable.
module ppc_power_attach
    import ppc_pkg::*;
#(
    parameter int SAFE0_CYC = SAFE0_CYC_DEF
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog monitors, per high-voltage path
    input wire logic [1:0] hv_clamp_over,
    input wire logic [1:0] hv_trip_drop,
    input wire logic [1:0] hv_rev_cmp,
    input wire logic [1:0] hv_rev_diode,
    // VBUS and cable supply monitors
    input wire logic vbus_over,
    input wire logic vbus_under,
    input wire logic vbus_above_safe5,
    input wire logic vbus_above_safe0,
    input wire logic cable_input_good,
    // CC termination detection
    input wire logic [1:0] cc1_term,
    input wire logic [1:0] cc2_term,
    // High-voltage switch control
    output logic [1:0] hv_gate,
    output logic [1:0] hv_clamp_en,
    output logic [1:0] hv_diode_mode,
    output logic [7:0] hv_clamp_limit,
    output logic [7:0] ovp_level,
    output logic [7:0] uvp_level,
    // External paths
    output logic ext_path_enable_a,
    output logic ext_path_enable_b,
    // Cable supply switch, bit 0 to channel one, bit 1 to channel two
    output logic [1:0] cable_supply_switch,
    output logic cable_ilim_en,
    // VBUS discharge and CC monitoring
    output logic vbus_pulldown,
    output logic [1:0] cc_monitor
);

    localparam int DG_MAX = DEGLITCH_CYC - 1;

    logic [CTRL_W-1:0] ctrl_ff;
    logic [23:0] limit_ff;
    logic [1:0] oc_latch_ff;
    logic dis_tmo_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [1:0] gate_ff;
    logic [1:0] clamp_en_ff;
    logic [1:0] diode_ff;
    logic ext_a_ff;
    logic ext_b_ff;
    logic [1:0] vconn_ff;
    logic ilim_ff;
    logic pd_ff;
    logic [1:0] mon_ff;
    logic [31:0] zero_cnt_ff;
    ppc_att_t st_ff;
    ppc_att_t nxt_st;
    ppc_path_cfg_t cfg [2];
    logic wr_acc;
    logic rd_acc;
    logic vbus_fault;
    logic vbus_req;
    logic zero_tgt;
    logic [1:0] vconn_tgt;
    logic [1:0] dg_hit;
    logic [1:0] oc_set;
    logic [31:0] status_rd;

    assign wr_acc = psel & penable & pready_ff & pwrite;
    assign rd_acc = psel & penable & ~pready_ff & ~pwrite;
    assign vbus_fault = vbus_over | vbus_under;
    assign cfg[0] = '{en: ctrl_ff[CTRL_P0_EN], src: ctrl_ff[CTRL_P0_SRC],
                      lim: limit_ff[LIM_P0_LSB +: 4]};
    assign cfg[1] = '{en: ctrl_ff[CTRL_P1_EN], src: ctrl_ff[CTRL_P1_SRC],
                      lim: limit_ff[LIM_P1_LSB +: 4]};

    ////////////////////////////////////////////////////////////////////////////
    // APB register file; one wait state so every answer comes from a flop

    assign status_rd = {20'h00000, pd_ff, vconn_ff, gate_ff, 4'(st_ff), dis_tmo_ff,
                        oc_latch_ff};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff &
                          ~(paddr == ADDR_CTRL || paddr == ADDR_LIMIT || paddr == ADDR_STATUS);
            if (rd_acc) begin
                case (paddr)
                    ADDR_CTRL: prdata_ff <= {21'h000000, ctrl_ff};
                    ADDR_LIMIT: prdata_ff <= {8'h00, limit_ff};
                    ADDR_STATUS: prdata_ff <= status_rd;
                    default: prdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RST; // RULE2
            limit_ff <= LIMIT_RST;
        end else if (wr_acc) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_ff <= pwdata[CTRL_W-1:0]; // RULE1
            end
            if (paddr == ADDR_LIMIT) begin
                limit_ff <= pwdata[23:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // High-voltage paths

    for (genvar i = 0; i < 2; i++) begin : g_path
        logic [15:0] dg_cnt_ff;
        logic rev_block;

        // Clamp deglitch runs while the path is set to source, even with the path disabled
        assign dg_hit[i] = cfg[i].src & hv_clamp_over[i] & (dg_cnt_ff == 16'(DG_MAX)); // RULE4
        assign oc_set[i] = dg_hit[i] | hv_trip_drop[i]; // RULE5
        assign rev_block = cfg[i].src ? hv_rev_cmp[i] : hv_rev_diode[i]; // RULE7

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dg_cnt_ff <= 16'h0000;
            end else if (cfg[i].src && hv_clamp_over[i] && !dg_hit[i]) begin
                dg_cnt_ff <= dg_cnt_ff + 16'h0001;
            end else begin
                dg_cnt_ff <= 16'h0000;
            end
        end

        // Set wins over a same-cycle software clear
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                oc_latch_ff[i] <= 1'b0;
            end else if (oc_set[i]) begin
                oc_latch_ff[i] <= 1'b1; // RULE25
            end else if (wr_acc && paddr == ADDR_STATUS && pwdata[ST_OCL_LSB + i]) begin
                oc_latch_ff[i] <= 1'b0; // RULE25
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                gate_ff[i] <= 1'b0;
                clamp_en_ff[i] <= 1'b0;
                diode_ff[i] <= 1'b0;
            end else begin
                gate_ff[i] <= cfg[i].en & ~oc_latch_ff[i] & ~oc_set[i] & ~vbus_fault // RULE6
                              & ~rev_block // RULE8
                              & (~cfg[i].src | vbus_req);
                clamp_en_ff[i] <= cfg[i].src & cfg[i].en; // RULE3
                diode_ff[i] <= ~cfg[i].src; // RULE9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External paths: voltage faults only, nothing current- or heat-related

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_a_ff <= 1'b0;
            ext_b_ff <= 1'b0;
        end else begin
            ext_a_ff <= ctrl_ff[CTRL_EXTA_CTL] & ctrl_ff[CTRL_EXTA_REQ] & ~vbus_fault; // RULE10
            ext_b_ff <= ctrl_ff[CTRL_EXTB_CTL] & ctrl_ff[CTRL_EXTB_REQ] & ~vbus_fault; // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source-side attach state

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            AT_SNK1: if (cc1_term != CC_RD) nxt_st = AT_OPEN; // RULE21
            AT_SNK2: if (cc2_term != CC_RD) nxt_st = AT_OPEN;
            AT_PWR1: if (cc2_term != CC_RD) nxt_st = AT_OPEN; // RULE23
            AT_PWR2: if (cc1_term != CC_RD) nxt_st = AT_OPEN;
            AT_DEBUG: if (cc1_term != CC_RD || cc2_term != CC_RD) nxt_st = AT_OPEN; // RULE24
            AT_AUDIO: if (cc1_term != CC_RA || cc2_term != CC_RA) nxt_st = AT_OPEN;
            AT_OPEN, AT_CAB1, AT_CAB2: begin
                // Open and cable-only states re-decode both pins every cycle
                case ({cc1_term, cc2_term})
                    {CC_RD, CC_OPEN}: nxt_st = AT_SNK1;
                    {CC_OPEN, CC_RD}: nxt_st = AT_SNK2;
                    {CC_RA, CC_OPEN}: nxt_st = AT_CAB1; // RULE22
                    {CC_OPEN, CC_RA}: nxt_st = AT_CAB2;
                    {CC_RA, CC_RD}: nxt_st = AT_PWR1;
                    {CC_RD, CC_RA}: nxt_st = AT_PWR2;
                    {CC_RD, CC_RD}: nxt_st = AT_DEBUG;
                    {CC_RA, CC_RA}: nxt_st = AT_AUDIO;
                    default: nxt_st = AT_OPEN; // RULE20
                endcase
            end
            default: nxt_st = AT_OPEN;
        endcase
        if (!ctrl_ff[CTRL_DFP_EN]) begin
            nxt_st = AT_OPEN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= AT_OPEN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign vbus_req = st_ff == AT_SNK1 || st_ff == AT_SNK2 || st_ff == AT_PWR1 ||
                      st_ff == AT_PWR2 || st_ff == AT_DEBUG;
    assign vconn_tgt = !ctrl_ff[CTRL_VCONN_EN] ? 2'h0 :
                       st_ff == AT_PWR1 ? 2'h1 : st_ff == AT_PWR2 ? 2'h2 : 2'h0; // RULE13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_ff <= 2'h3;
        end else begin
            case (st_ff)
                AT_SNK1, AT_PWR2: mon_ff <= 2'h1;
                AT_SNK2, AT_PWR1: mon_ff <= 2'h2;
                default: mon_ff <= 2'h3;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cable supply switch

    // Input-good only gates the closing; a closed switch rides through a sag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vconn_ff <= 2'h0;
            ilim_ff <= 1'b0;
        end else begin
            if (vconn_tgt == 2'h0) begin
                vconn_ff <= 2'h0;
            end else if (vconn_ff == vconn_tgt) begin
                vconn_ff <= vconn_ff; // RULE17
            end else if (cable_input_good) begin
                vconn_ff <= vconn_tgt; // RULE16
            end else begin
                vconn_ff <= 2'h0;
            end
            // No reverse blocking is requested while conducting
            ilim_ff <= vconn_tgt != 2'h0; // RULE14 RULE15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // VBUS discharge

    assign zero_tgt = ctrl_ff[CTRL_ZERO_REQ] | (ctrl_ff[CTRL_DFP_EN] & ~vbus_req);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_ff <= 1'b0;
            zero_cnt_ff <= 32'h00000000;
            dis_tmo_ff <= 1'b0;
        end else begin
            if (gate_ff != 2'h0) begin
                pd_ff <= 1'b0;
            end else if (zero_tgt) begin
                pd_ff <= vbus_above_safe0; // RULE19
            end else begin
                pd_ff <= vbus_above_safe5; // RULE18
            end
            // Discharge time budget, reported rather than enforced
            if (pd_ff && zero_tgt) begin
                zero_cnt_ff <= zero_cnt_ff + 32'h00000001;
            end else begin
                zero_cnt_ff <= 32'h00000000;
            end
            if (pd_ff && zero_tgt && zero_cnt_ff == 32'(SAFE0_CYC)) begin
                dis_tmo_ff <= 1'b1; // RULE19
            end else if (wr_acc && paddr == ADDR_STATUS && pwdata[ST_DTO]) begin
                dis_tmo_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign hv_gate = gate_ff;
    assign hv_clamp_en = clamp_en_ff;
    assign hv_diode_mode = diode_ff;
    assign ext_path_enable_a = ext_a_ff;
    assign ext_path_enable_b = ext_b_ff;
    assign cable_supply_switch = vconn_ff;
    assign cable_ilim_en = ilim_ff;
    assign vbus_pulldown = pd_ff;
    assign cc_monitor = mon_ff;
    assign hv_clamp_limit = limit_ff[7:0];
    assign ovp_level = limit_ff[LIM_OVP_LSB +: 8];
    assign uvp_level = limit_ff[LIM_UVP_LSB +: 8];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_clamp_src;
        hv_clamp_en[0] |-> $past(ctrl_ff[CTRL_P0_SRC]);
    endproperty
    a_clamp_src: assert property (p_clamp_src) else $error("clamp on a sink path"); // RULE3

    property p_deglitch;
        dg_hit[1] |=> oc_latch_ff[1] ##1 !hv_gate[1];
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("clamp expiry not latched"); // RULE4

    property p_trip;
        hv_trip_drop[0] |=> !hv_gate[0] && oc_latch_ff[0];
    endproperty
    a_trip: assert property (p_trip) else $error("trip did not open switch"); // RULE5

    property p_vfault;
        vbus_fault |=> hv_gate == 2'h0 && !ext_path_enable_a && !ext_path_enable_b;
    endproperty
    a_vfault: assert property (p_vfault) else $error("path on during voltage fault"); // RULE6

    property p_rev;
        (hv_rev_cmp[1] && ctrl_ff[CTRL_P1_SRC]) || (hv_rev_diode[1] && !ctrl_ff[CTRL_P1_SRC])
            |=> !hv_gate[1];
    endproperty
    a_rev: assert property (p_rev) else $error("reverse current not blocked"); // RULE7

    property p_vconn_good;
        $rose(cable_supply_switch != 2'h0) |-> $past(cable_input_good);
    endproperty
    a_vconn_good: assert property (p_vconn_good) else $error("vconn closed on bad input"); // RULE16

    property p_vconn_hold;
        cable_supply_switch != 2'h0 && vconn_tgt == cable_supply_switch
            |=> cable_supply_switch == $past(cable_supply_switch);
    endproperty
    a_vconn_hold: assert property (p_vconn_hold) else $error("vconn dropped on its own"); // RULE17

    property p_vconn_one;
        cable_supply_switch != 2'h3;
    endproperty
    a_vconn_one: assert property (p_vconn_one) else $error("vconn on both pins"); // RULE13

    property p_open_nopower;
        st_ff == AT_OPEN ##1 st_ff == AT_OPEN |=> hv_gate[1] == 1'b0 || !ctrl_ff[CTRL_P1_SRC];
    endproperty
    a_open_nopower: assert property (p_open_nopower) else $error("power while open"); // RULE20

    property p_latch_hold;
        oc_latch_ff[0] && !(wr_acc && paddr == ADDR_STATUS) |=> oc_latch_ff[0];
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch cleared itself"); // RULE25

    property p_pd5;
        hv_gate == 2'h0 && !zero_tgt && vbus_above_safe5 |=> vbus_pulldown;
    endproperty
    a_pd5: assert property (p_pd5) else $error("no pull-down above safe level"); // RULE18

    c_attach_pwr: cover property (st_ff == AT_PWR1 ##[1:20] cable_supply_switch == 2'h1);
    c_trip: cover property (hv_gate[0] ##1 oc_latch_ff[0]);
    c_discharge: cover property ($rose(vbus_pulldown) ##[1:50] $fell(vbus_pulldown));

endmodule : ppc_power_attach

// File: inc/ppc_pkg.sv
package ppc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Control register fields
    localparam int CTRL_P0_EN = 0;
    localparam int CTRL_P0_SRC = 1;
    localparam int CTRL_P1_EN = 2;
    localparam int CTRL_P1_SRC = 3;
    localparam int CTRL_EXTA_CTL = 4;
    localparam int CTRL_EXTB_CTL = 5;
    localparam int CTRL_EXTA_REQ = 6;
    localparam int CTRL_EXTB_REQ = 7;
    localparam int CTRL_DFP_EN = 8;
    localparam int CTRL_VCONN_EN = 9;
    localparam int CTRL_ZERO_REQ = 10;
    localparam int CTRL_W = 11;
    // First path sinks, second path sources, both held off
    localparam logic [10:0] CTRL_RST = 11'h008;

    // Limit register fields
    localparam int LIM_P0_LSB = 0;
    localparam int LIM_P1_LSB = 4;
    localparam int LIM_OVP_LSB = 8;
    localparam int LIM_UVP_LSB = 16;
    localparam logic [23:0] LIMIT_RST = 24'h000000;

    // Status register fields
    localparam int ST_OCL_LSB = 0;
    localparam int ST_DTO = 2;
    localparam int ST_ATT_LSB = 3;
    localparam int ST_GATE_LSB = 7;
    localparam int ST_VCONN_LSB = 9;
    localparam int ST_PD = 11;

    // CC pin termination codes from the detection comparators
    localparam logic [1:0] CC_OPEN = 2'h0;
    localparam logic [1:0] CC_RA = 2'h1;
    localparam logic [1:0] CC_RD = 2'h2;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int DEGLITCH_NS = 10000;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAFE0_MS = 650;
    localparam int SAFE0_CYC_DEF = SAFE0_MS * 1000000 / CLK_PERIOD_NS;

    typedef struct packed {
        logic en;
        logic src;
        logic [3:0] lim;
    } ppc_path_cfg_t;

    typedef enum logic [3:0] {
        AT_OPEN, AT_SNK1, AT_SNK2, AT_CAB1, AT_CAB2,
        AT_PWR1, AT_PWR2, AT_DEBUG, AT_AUDIO
    } ppc_att_t;

endpackage : ppc_pkg

// File: bench/ppc_partner.sv
`timescale 1ns/1ps
module ppc_partner
    import ppc_pkg::*;
#(
    parameter int FAST_DLY = 4,
    parameter int SLOW_DLY = 400
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Device side
    input wire logic [1:0] hv_gate,
    input wire logic vbus_pulldown,
    // Bench controls
    input wire logic [1:0] cc1_req,
    input wire logic [1:0] cc2_req,
    input wire logic vbus_hi,
    input wire logic slow,
    // Port wires
    output logic [1:0] cc1_term,
    output logic [1:0] cc2_term,
    output logic vbus_above_safe5,
    output logic vbus_above_safe0
);
    logic [1:0] lvl_ff;
    int dly_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Terminations are whatever the attached party presents
    assign cc1_term = cc1_req;
    assign cc2_term = cc2_req;
    assign vbus_above_safe5 = lvl_ff > 2'h1;
    assign vbus_above_safe0 = lvl_ff != 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus capacitance: VBUS never drops at once, one level per delay while pulled down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_ff <= 2'h0;
            dly_ff <= 0;
        end else if (|hv_gate) begin
            lvl_ff <= vbus_hi ? 2'h2 : 2'h1;
            dly_ff <= 0;
        end else if (vbus_pulldown && lvl_ff != 2'h0) begin
            if (dly_ff >= (slow ? SLOW_DLY : FAST_DLY)) begin
                lvl_ff <= lvl_ff - 2'h1;
                dly_ff <= 0;
            end else begin
                dly_ff <= dly_ff + 1;
            end
        end
    end
endmodule : ppc_partner

// File: bench/ppc_power_attach_test.sv
`timescale 1ns/1ps
module ppc_power_attach_test;
    import ppc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
    logic [7:0] paddr, hv_clamp_limit, ovp_level, uvp_level;
    logic [31:0] pwdata, prdata, rv;
    logic [1:0] hv_clamp_over, hv_trip_drop, hv_rev_cmp, hv_rev_diode, cc1_term, cc2_term;
    logic [1:0] hv_gate, hv_clamp_en, hv_diode_mode, cable_supply_switch, cc_monitor;
    logic [1:0] cc1_req, cc2_req;
    logic vbus_over, vbus_under, vbus_above_safe5, vbus_above_safe0, cable_input_good;
    logic ext_path_enable_a, ext_path_enable_b, cable_ilim_en, vbus_pulldown, vbus_hi, slow;
    int miscompares, comparisons;

    ppc_power_attach #(.SAFE0_CYC(200)) uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .hv_clamp_over, .hv_trip_drop, .hv_rev_cmp, .hv_rev_diode, .vbus_over,
        .vbus_under, .vbus_above_safe5, .vbus_above_safe0, .cable_input_good, .cc1_term,
        .cc2_term, .hv_gate, .hv_clamp_en, .hv_diode_mode, .hv_clamp_limit, .ovp_level,
        .uvp_level, .ext_path_enable_a, .ext_path_enable_b, .cable_supply_switch,
        .cable_ilim_en, .vbus_pulldown, .cc_monitor
    );
    ppc_partner partner (
        .pclk, .presetn, .hv_gate, .vbus_pulldown, .cc1_req, .cc2_req, .vbus_hi, .slow,
        .cc1_term, .cc2_term, .vbus_above_safe5, .vbus_above_safe0
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // Starts on an edge of its own so psel is never driven twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(cc_monitor, 2'h3);
        chk(hv_gate, 2'h0);
        rd(ADDR_CTRL);
        chk(rv, 32'h00000008);
        rd(ADDR_LIMIT);
        chk(rv, 32'h0);
        rd(ADDR_STATUS);
        chk(rv, 32'h0);
        rd(8'h0c);
        chk({re, rv[30:0]}, {1'b1, 31'h0});
    endtask : t_reset

    // Two bits per case: 0 open, 1 Ra, 2 Rd; last case is the audio accessory
    task automatic t_attach;
        logic [17:0] p1 = 18'h1a448;
        logic [17:0] p2 = 18'h19920;
        logic [17:0] vc = 18'h02400;
        logic [17:0] mn = 18'h3dbe7;
        logic [8:0] g1 = 9'h0e6;
        wr(ADDR_CTRL, 32'h0000030c);
        for (int i = 0; i < 9; i++) begin
            cc1_req <= p1[2*i +: 2];
            cc2_req <= p2[2*i +: 2];
            cyc(4);
            chk(hv_gate[1], g1[i]);
            chk(cable_supply_switch, vc[2*i +: 2]);
            chk(cable_ilim_en, |vc[2*i +: 2]);
            chk(cc_monitor, mn[2*i +: 2]);
            rd(ADDR_STATUS);
            chk(rv[10:3], {vc[2*i +: 2], g1[i], 1'b0, 4'(i)});
            cc1_req <= CC_OPEN;
            cc2_req <= CC_OPEN;
            cyc(12);
        end
    endtask : t_attach

    task automatic t_vconn;
        cable_input_good <= 1'b0;
        cc1_req <= CC_RA;
        cc2_req <= CC_RD;
        cyc(4);
        chk(cable_supply_switch, 2'h0);
        cable_input_good <= 1'b1;
        cyc(3);
        chk(cable_supply_switch, 2'h1);
        cable_input_good <= 1'b0;
        cyc(3);
        chk(cable_supply_switch, 2'h1);
        cable_input_good <= 1'b1;
        cc1_req <= CC_RD;
        cc2_req <= CC_OPEN;
    endtask : t_vconn

    task automatic t_clamp;
        wr(ADDR_CTRL, 32'h00000107);
        cyc(3);
        chk({hv_diode_mode, hv_clamp_en}, 4'h9);
        wr(ADDR_LIMIT, 32'h00a0b0c3);
        wr(ADDR_CTRL, 32'h0000030d);
        cyc(4);
        chk({hv_clamp_limit, ovp_level, uvp_level}, 24'hc3b0a0);
        chk({hv_diode_mode, hv_clamp_en}, 4'h6);
        chk(hv_gate, 2'h3);
        hv_clamp_over <= 2'h3;
        cyc(DEGLITCH_CYC - 4);
        chk(hv_gate, 2'h3);
        hv_clamp_over <= 2'h0;
        cyc(2);
        hv_clamp_over <= 2'h3;
        cyc(DEGLITCH_CYC + 4);
        chk(hv_gate, 2'h1);
        hv_clamp_over <= 2'h0;
        cyc(4);
        chk(hv_gate, 2'h1);
        rd(ADDR_STATUS);
        chk(rv[1:0], 2'h2);
        wr(ADDR_STATUS, 32'h00000002);
        cyc(3);
        chk(hv_gate, 2'h3);
        hv_trip_drop <= 2'h1;
        cyc(3);
        hv_trip_drop <= 2'h0;
        cyc(3);
        chk(hv_gate, 2'h2);
        rd(ADDR_STATUS);
        chk(rv[1:0], 2'h1);
        wr(ADDR_STATUS, 32'h00000001);
        cyc(3);
        chk(hv_gate, 2'h3);
    endtask : t_clamp

    // Each path must ignore the reverse detector of the other mode
    task automatic t_reverse;
        hv_rev_cmp <= 2'h1;
        hv_rev_diode <= 2'h2;
        cyc(3);
        chk(hv_gate, 2'h3);
        hv_rev_cmp <= 2'h2;
        hv_rev_diode <= 2'h1;
        cyc(3);
        chk(hv_gate, 2'h0);
        hv_rev_cmp <= 2'h0;
        hv_rev_diode <= 2'h0;
        wr(ADDR_STATUS, 32'h00000003);
        cyc(3);
        chk(hv_gate, 2'h3);
    endtask : t_reverse

    // Enables are always driven, so the board pull-down only covers reset
    task automatic t_volt;
        wr(ADDR_CTRL, 32'h000003fd);
        cyc(3);
        chk({ext_path_enable_a, ext_path_enable_b}, 2'h3);
        hv_trip_drop <= 2'h3;
        cyc(3);
        chk({hv_gate, ext_path_enable_a, ext_path_enable_b}, 4'h3);
        hv_trip_drop <= 2'h0;
        wr(ADDR_STATUS, 32'h00000003);
        vbus_over <= 1'b1;
        cyc(3);
        chk({hv_gate, ext_path_enable_a, ext_path_enable_b}, 4'h0);
        vbus_over <= 1'b0;
        vbus_under <= 1'b1;
        cyc(3);
        chk({hv_gate, ext_path_enable_a, ext_path_enable_b}, 4'h0);
        vbus_under <= 1'b0;
        cyc(4);
        chk({hv_gate, ext_path_enable_a, ext_path_enable_b}, 4'hf);
    endtask : t_volt

    task automatic t_discharge;
        vbus_hi <= 1'b1;
        cyc(3);
        wr(ADDR_CTRL, 32'h00000308);
        cyc(3);
        chk(vbus_pulldown, 1'b1);
        cyc(20);
        chk({vbus_pulldown, vbus_above_safe0}, 2'h1);
        wr(ADDR_CTRL, 32'h00000708);
        cyc(3);
        chk(vbus_pulldown, 1'b1);
        cyc(20);
        chk({vbus_pulldown, vbus_above_safe0}, 2'h0);
        slow <= 1'b1;
        wr(ADDR_CTRL, 32'h0000030d);
        cyc(3);
        wr(ADDR_CTRL, 32'h00000708);
        cyc(230);
        chk(vbus_pulldown, 1'b1);
        rd(ADDR_STATUS);
        chk(rv[2], 1'b1);
    endtask : t_discharge

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        final_report();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {hv_clamp_over, hv_trip_drop, hv_rev_cmp, hv_rev_diode, cc1_req, cc2_req} = '0;
        {vbus_over, vbus_under, vbus_hi, slow} = '0;
        cable_input_good = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_attach();
        t_vconn();
        t_clamp();
        t_reverse();
        t_volt();
        t_discharge();
        final_report();
    end
endmodule : ppc_power_attach_test
